// ---- inc/sccb_pkg.sv ----
// Package for the serial channel configuration bank.
// Assumes one 125 MHz clock and a synchronous active-low reset.
package sccb_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_CH = 4;
    localparam int CH_W = 2;
    localparam int RATE_W = 4;
    localparam int TMO_W = 20;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // Register offsets (register indexes)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CH_CFG0 = 4'h0;
    localparam logic [ADDR_W-1:0] REG_CH_CFG1 = 4'h1;
    localparam logic [ADDR_W-1:0] REG_CH_CFG2 = 4'h2;
    localparam logic [ADDR_W-1:0] REG_CH_CFG3 = 4'h3;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h5;
    localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h6;

    // ------------------------------------------------------------
    // Channel config field layout
    // ------------------------------------------------------------
    localparam int F_RATE_LSB = 0;
    localparam int F_SHARED = 4;
    localparam int F_TERM = 5;
    localparam int F_BIAS = 6;
    localparam int CFG_W = 7;

    // Status register fields
    localparam int S_FAULT_EXP = 0;
    localparam int S_LINK_END = 1;
    localparam int S_LEVEL_LSB = 2;

    // Interrupt events: bit i = channel i config written, bit 4 = fault edge
    localparam int IRQ_W = 5;
    localparam int IRQ_FAULT = 4;

    // ------------------------------------------------------------
    // Data rate codes
    // ------------------------------------------------------------
    typedef enum logic [RATE_W-1:0] {
        SCCB_R1K2 = 4'h0,
        SCCB_R2K4 = 4'h1,
        SCCB_R4K8 = 4'h2,
        SCCB_R9K6 = 4'h3,
        SCCB_R19K2 = 4'h4,
        SCCB_R38K4 = 4'h5,
        SCCB_R57K6 = 4'h6,
        SCCB_R76K8 = 4'h7,
        SCCB_R115K = 4'h8,
        SCCB_R153K = 4'h9,
        SCCB_RUNDOC = 4'ha,
        SCCB_R230K = 4'hb,
        SCCB_R460K = 4'hc
    } sccb_rate_e;

    localparam logic [RATE_W-1:0] RATE_RESET = SCCB_R9K6;
    localparam logic [RATE_W-1:0] RATE_LAST = SCCB_R460K;

    // Rates in bits per second, by code
    localparam int RATE_BPS [13] = '{1200, 2400, 4800, 9600, 19200, 38400,
        57600, 76800, 115200, 153600, 192000, 230400, 460800};

    // Driver turnaround timeout: this many bit periods
    localparam int TMO_BITS = 10;
    localparam int CLK_HZ = 125000000;

    // ------------------------------------------------------------
    // Menu
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SCCB_M_L1 = 3'b000,
        SCCB_M_L2 = 3'b001,
        SCCB_M_L3 = 3'b010,
        SCCB_M_EDIT = 3'b011
    } sccb_menu_e;

    typedef enum logic [2:0] {
        SCCB_I_TYPE = 3'b000,
        SCCB_I_RATE = 3'b001,
        SCCB_I_TERM = 3'b010,
        SCCB_I_BIAS = 3'b011,
        SCCB_I_BACK = 3'b100
    } sccb_item_e;

    localparam logic [1:0] MENU_LEVEL_1 = 2'h1;
    localparam logic [1:0] MENU_LEVEL_2 = 2'h2;
    localparam logic [1:0] MENU_LEVEL_3 = 2'h3;

endpackage

// ---- core/sccb_timeout.sv ----
// Turns a rate code into a driver timeout count, held in a register.
// Assumes rate codes of the shared package.
module sccb_timeout
    import sccb_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Channel settings
    input wire logic [sccb_pkg::RATE_W-1:0] rate,
    input wire logic shared_bus,
    // Result
    output logic [sccb_pkg::TMO_W-1:0] timeout_q
);
    import sccb_pkg::*;

    function automatic logic [TMO_W-1:0] tmo_of(input logic [RATE_W-1:0] r);
        int idx;
        idx = (r > RATE_LAST) ? 0 : int'(r);
        return TMO_W'((CLK_HZ / RATE_BPS[idx]) * TMO_BITS);
    endfunction

    // Point-to-point keeps the rate but drives no timeout
    always_ff @(posedge clk) begin
        if (!resetn) begin
            timeout_q <= '0;
        end else if (shared_bus) begin
            timeout_q <= tmo_of(rate);
        end else begin
            timeout_q <= '0;
        end
    end

endmodule // sccb_timeout

// ---- core/sccb_bank.sv ----
// Configuration bank for four balanced serial channels, with card-edge menu.
// Assumes synchronous inputs and a one-cycle-strobe register port.
// Notes on behaviour
// - Rate item offered only while the channel is shared-bus type.
// - Selected rate sets the channel driver network timeout only while shared-bus type.
// - Rate setting encodes thirteen rates, one of them undocumented.
// - Reset leaves every channel rate at 9.6 kb/s.
// - Rate writable from the menu and from the remote path.
// - Four channels, independent settings, chosen by channel index first.
// - Termination enable stored per channel, on or off.
// - Reset leaves termination off.
// - Effective bias only when bias and termination both on.
// - Reset leaves bias setting off.
// - Press on a setting commits value and returns to level 3.
// - Back on level 3 returns to level 2.
// - Local fault reaches frame status bus only with export jumper on.
// - Legacy control jumper is ignored.
// - Reset leaves line type point-to-point.
module sccb_bank
    import sccb_pkg::*;
#(
    parameter int N_CH = sccb_pkg::NUM_CH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [sccb_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [sccb_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [sccb_pkg::DATA_W-1:0] reg_rdata,
    // Card-edge keys, one-cycle pulses
    input wire logic key_up,
    input wire logic key_down,
    input wire logic key_push,
    // Jumpers and fault
    input wire logic fault_export_on,
    input wire logic legacy_ctrl_jumper,
    input wire logic link_end_letter,
    input wire logic local_fault,
    // Channel outputs
    output logic [N_CH-1:0] shared_bus_q,
    output logic [N_CH-1:0] term_en_q,
    output logic [N_CH-1:0] bias_en_q,
    output logic [N_CH*sccb_pkg::TMO_W-1:0] drv_timeout,
    // Menu view
    output logic [1:0] menu_level_q,
    output logic [sccb_pkg::CH_W-1:0] menu_ch_q,
    output logic [2:0] menu_item_q,
    output logic [sccb_pkg::RATE_W-1:0] menu_value_q,
    // Frame status and interrupt
    output logic frame_fault_q,
    output logic irq_q
);
    import sccb_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [RATE_W-1:0] rate_q [N_CH];
    logic [N_CH-1:0] shared_q;
    logic [N_CH-1:0] term_q;
    logic [N_CH-1:0] bias_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic fault_d1_q;
    sccb_menu_e menu_q;
    sccb_item_e item_q;
    logic [CH_W-1:0] ch_q;
    logic [RATE_W-1:0] val_q;

    // Menu commit, channel-wide
    logic m_commit;
    logic [CH_W-1:0] m_ch;
    sccb_item_e m_item;
    logic [RATE_W-1:0] m_val;

    function automatic logic is_cfg(input logic [ADDR_W-1:0] a);
        return a <= REG_CH_CFG3;
    endfunction

    // Legacy jumper has no effect anywhere
    logic unused_legacy;
    assign unused_legacy = legacy_ctrl_jumper;

    // ------------------------------------------------------------
    // Menu walker
    // ------------------------------------------------------------
    // Item list on level 3 skips rate unless shared-bus
    function automatic sccb_item_e next_item(input sccb_item_e it, input logic up,
                                             input logic shb);
        sccb_item_e n;
        n = it;
        if (up) begin
            unique case (it)
                SCCB_I_TYPE: n = shb ? SCCB_I_RATE : SCCB_I_TERM;
                SCCB_I_RATE: n = SCCB_I_TERM;
                SCCB_I_TERM: n = SCCB_I_BIAS;
                SCCB_I_BIAS: n = SCCB_I_BACK;
                SCCB_I_BACK: n = SCCB_I_TYPE;
                default: n = SCCB_I_TYPE;
            endcase
        end else begin
            unique case (it)
                SCCB_I_TYPE: n = SCCB_I_BACK;
                SCCB_I_RATE: n = SCCB_I_TYPE;
                SCCB_I_TERM: n = shb ? SCCB_I_RATE : SCCB_I_TYPE;
                SCCB_I_BIAS: n = SCCB_I_TERM;
                SCCB_I_BACK: n = SCCB_I_BIAS;
                default: n = SCCB_I_TYPE;
            endcase
        end
        return n;
    endfunction

    function automatic logic [RATE_W-1:0] cur_val(input sccb_item_e it,
                                                  input logic [CH_W-1:0] c);
        unique case (it)
            SCCB_I_RATE: return rate_q[c];
            SCCB_I_TYPE: return RATE_W'(shared_q[c]);
            SCCB_I_TERM: return RATE_W'(term_q[c]);
            SCCB_I_BIAS: return RATE_W'(bias_q[c]);
            default: return '0;
        endcase
    endfunction

    logic [RATE_W-1:0] val_max;
    assign val_max = (item_q == SCCB_I_RATE) ? RATE_LAST : RATE_W'(1);

    always_comb begin
        m_commit = (menu_q == SCCB_M_EDIT) && key_push;
        m_ch = ch_q;
        m_item = item_q;
        m_val = val_q;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            menu_q <= SCCB_M_L1;
            item_q <= SCCB_I_TYPE;
            ch_q <= '0;
            val_q <= '0;
        end else begin
            unique case (menu_q)
                SCCB_M_L1: begin
                    if (key_push) begin
                        menu_q <= SCCB_M_L2;
                    end
                end
                SCCB_M_L2: begin
                    // Channel index chosen before any setting
                    if (key_up) begin
                        ch_q <= ch_q + 1'b1;
                    end else if (key_down) begin
                        ch_q <= ch_q - 1'b1;
                    end else if (key_push) begin
                        menu_q <= SCCB_M_L3;
                        item_q <= SCCB_I_TYPE;
                    end
                end
                SCCB_M_L3: begin
                    if (key_up || key_down) begin
                        item_q <= next_item(item_q, key_up, shared_q[ch_q]);
                    end else if (key_push) begin
                        if (item_q == SCCB_I_BACK) begin
                            menu_q <= SCCB_M_L2;
                        end else if (item_q == SCCB_I_RATE && !shared_q[ch_q]) begin
                            // Rate hidden under the cursor: refuse the edit
                            item_q <= SCCB_I_TYPE;
                        end else begin
                            menu_q <= SCCB_M_EDIT;
                            val_q <= cur_val(item_q, ch_q);
                        end
                    end else if (item_q == SCCB_I_RATE && !shared_q[ch_q]) begin
                        item_q <= SCCB_I_TYPE;
                    end
                end
                SCCB_M_EDIT: begin
                    if (key_up) begin
                        val_q <= (val_q >= val_max) ? '0 : val_q + 1'b1;
                    end else if (key_down) begin
                        val_q <= (val_q == '0) ? val_max : val_q - 1'b1;
                    end else if (key_push) begin
                        menu_q <= SCCB_M_L3;
                    end
                end
                default: menu_q <= SCCB_M_L1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Channel settings, written by menu or remote path
    // ------------------------------------------------------------
    logic [N_CH-1:0] ch_changed;

    for (genvar g = 0; g < N_CH; g++) begin : g_ch
        logic r_wr;
        logic m_wr;
        logic [RATE_W-1:0] w_rate;
        assign r_wr = reg_wr && is_cfg(reg_addr) && (reg_addr[CH_W-1:0] == CH_W'(g));
        assign m_wr = m_commit && (m_ch == CH_W'(g));
        assign w_rate = reg_wdata[F_RATE_LSB +: RATE_W];
        assign ch_changed[g] = r_wr || m_wr;

        always_ff @(posedge clk) begin
            if (!resetn) begin
                rate_q[g] <= RATE_RESET;
                shared_q[g] <= 1'b0;
                term_q[g] <= 1'b0;
                bias_q[g] <= 1'b0;
            end else if (r_wr) begin
                // Out-of-range rate codes keep the old value
                if (w_rate <= RATE_LAST) begin
                    rate_q[g] <= w_rate;
                end
                shared_q[g] <= reg_wdata[F_SHARED];
                term_q[g] <= reg_wdata[F_TERM];
                bias_q[g] <= reg_wdata[F_BIAS];
            end else if (m_wr) begin
                unique case (m_item)
                    SCCB_I_RATE: rate_q[g] <= m_val;
                    SCCB_I_TYPE: shared_q[g] <= m_val[0];
                    SCCB_I_TERM: term_q[g] <= m_val[0];
                    SCCB_I_BIAS: bias_q[g] <= m_val[0];
                    default: ;
                endcase
            end
        end

        always_ff @(posedge clk) begin
            if (!resetn) begin
                shared_bus_q[g] <= 1'b0;
                term_en_q[g] <= 1'b0;
                bias_en_q[g] <= 1'b0;
            end else begin
                shared_bus_q[g] <= shared_q[g];
                term_en_q[g] <= term_q[g];
                // Bias guarded by termination to protect the input
                bias_en_q[g] <= bias_q[g] & term_q[g];
            end
        end

        sccb_timeout u_tmo (
            .clk(clk),
            .resetn(resetn),
            .rate(rate_q[g]),
            .shared_bus(shared_q[g]),
            .timeout_q(drv_timeout[g*TMO_W +: TMO_W])
        );
    end

    // ------------------------------------------------------------
    // Fault export and interrupts
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            frame_fault_q <= 1'b0;
            fault_d1_q <= 1'b0;
        end else begin
            frame_fault_q <= local_fault & fault_export_on;
            fault_d1_q <= local_fault;
        end
    end

    // One bit per channel for any write, top bit for a rising fault
    logic [IRQ_W-1:0] irq_set;
    assign irq_set = {local_fault & ~fault_d1_q, ch_changed};

    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
        end else begin
            // Set wins over a same-cycle clear
            if (reg_wr && reg_addr == REG_IRQ_STAT) begin
                irq_stat_q <= (irq_stat_q & ~reg_wdata[IRQ_W-1:0]) | irq_set;
            end else begin
                irq_stat_q <= irq_stat_q | irq_set;
            end
            if (reg_wr && reg_addr == REG_IRQ_MASK) begin
                irq_mask_q <= reg_wdata[IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |((irq_stat_q | irq_set) & irq_mask_q);
        end
    end

    // ------------------------------------------------------------
    // Read path and menu view
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= '0;
            // Unmapped indexes fall through and read as zero
            if (is_cfg(reg_addr)) begin
                reg_rdata[F_RATE_LSB +: RATE_W] <= rate_q[reg_addr[CH_W-1:0]];
                reg_rdata[F_SHARED] <= shared_q[reg_addr[CH_W-1:0]];
                reg_rdata[F_TERM] <= term_q[reg_addr[CH_W-1:0]];
                reg_rdata[F_BIAS] <= bias_q[reg_addr[CH_W-1:0]];
            end else if (reg_addr == REG_STATUS) begin
                reg_rdata[S_FAULT_EXP] <= fault_export_on;
                reg_rdata[S_LINK_END] <= link_end_letter;
                reg_rdata[S_LEVEL_LSB +: 2] <= menu_level_q;
            end else if (reg_addr == REG_IRQ_STAT) begin
                reg_rdata[IRQ_W-1:0] <= irq_stat_q;
            end else if (reg_addr == REG_IRQ_MASK) begin
                reg_rdata[IRQ_W-1:0] <= irq_mask_q;
            end
        end else begin
            reg_rdata <= '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            menu_level_q <= MENU_LEVEL_1;
            menu_ch_q <= '0;
            menu_item_q <= '0;
            menu_value_q <= '0;
        end else begin
            unique case (menu_q)
                SCCB_M_L1: menu_level_q <= MENU_LEVEL_1;
                SCCB_M_L2: menu_level_q <= MENU_LEVEL_2;
                // Edit state shows as level 3
                default: menu_level_q <= MENU_LEVEL_3;
            endcase
            menu_ch_q <= ch_q;
            menu_item_q <= item_q;
            menu_value_q <= val_q;
        end
    end

endmodule // sccb_bank

// ---- verification/sccb_bank_props.sv ----
// Checker for the serial channel configuration bank.
// Assumes it is bound to sccb_bank and sees only its ports.
module sccb_bank_props
    import sccb_pkg::*;
#(
    parameter int N_CH = sccb_pkg::NUM_CH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [sccb_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [sccb_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [sccb_pkg::DATA_W-1:0] reg_rdata,
    // Keys, jumpers, fault
    input wire logic key_up,
    input wire logic key_down,
    input wire logic key_push,
    input wire logic fault_export_on,
    input wire logic legacy_ctrl_jumper,
    input wire logic link_end_letter,
    input wire logic local_fault,
    // Channel outputs
    input wire logic [N_CH-1:0] shared_bus_q,
    input wire logic [N_CH-1:0] term_en_q,
    input wire logic [N_CH-1:0] bias_en_q,
    input wire logic [N_CH*sccb_pkg::TMO_W-1:0] drv_timeout,
    // Menu, status, interrupt
    input wire logic [1:0] menu_level_q,
    input wire logic [sccb_pkg::CH_W-1:0] menu_ch_q,
    input wire logic [2:0] menu_item_q,
    input wire logic [sccb_pkg::RATE_W-1:0] menu_value_q,
    input wire logic frame_fault_q,
    input wire logic irq_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // Menu view lags a key by two edges, so only judge keys after a quiet spell
    logic k1_q;
    logic k2_q;
    logic quiet;
    logic push_only;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    always_ff @(posedge clk) begin
        k1_q <= key_up | key_down | key_push;
        k2_q <= k1_q;
    end
    assign quiet = !k1_q && !k2_q;
    assign push_only = key_push && !key_up && !key_down && quiet;

    chk_bias_needs_term: assert property (!(|(bias_en_q & ~term_en_q)))
        else $error("bias enable without termination");
    chk_fault_gate: assert property ($past(resetn) |->
        frame_fault_q == $past(local_fault && fault_export_on))
        else $error("frame fault not gated by export jumper");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data outside read answer cycle");
    chk_l1_push_l2: assert property (push_only && menu_level_q == MENU_LEVEL_1
        |-> ##2 menu_level_q == MENU_LEVEL_2)
        else $error("push on level 1 did not reach level 2");
    chk_l2_push_l3: assert property (push_only && menu_level_q == MENU_LEVEL_2
        |-> ##2 menu_level_q == MENU_LEVEL_3)
        else $error("push on level 2 did not reach level 3");
    chk_setting_l3: assert property (push_only && menu_level_q == MENU_LEVEL_3
        && menu_item_q != 3'h4 |-> ##2 menu_level_q == MENU_LEVEL_3)
        else $error("push on a setting left level 3");
    chk_back_l2: assert property (push_only && menu_level_q == MENU_LEVEL_3
        && menu_item_q == 3'h4 |-> ##2 menu_level_q == MENU_LEVEL_2)
        else $error("back item did not return to level 2");
    chk_rate_item: assert property ($changed(menu_item_q) && menu_item_q == 3'h1
        |-> shared_bus_q[menu_ch_q])
        else $error("rate item offered on point-to-point channel");

    for (genvar g = 0; g < N_CH; g++) begin : g_ch
        chk_p2p_no_tmo: assert property (!shared_bus_q[g] |->
            drv_timeout[g*TMO_W +: TMO_W] == '0)
            else $error("timeout on point-to-point channel");
        chk_shared_tmo: assert property (shared_bus_q[g] |->
            drv_timeout[g*TMO_W +: TMO_W] != '0)
            else $error("no timeout on shared-bus channel");
    end
endmodule // sccb_bank_props

bind sccb_bank sccb_bank_props #(.N_CH(N_CH)) i_props (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .key_up(key_up),
    .key_down(key_down), .key_push(key_push), .fault_export_on(fault_export_on),
    .legacy_ctrl_jumper(legacy_ctrl_jumper), .link_end_letter(link_end_letter),
    .local_fault(local_fault), .shared_bus_q(shared_bus_q), .term_en_q(term_en_q),
    .bias_en_q(bias_en_q), .drv_timeout(drv_timeout), .menu_level_q(menu_level_q),
    .menu_ch_q(menu_ch_q), .menu_item_q(menu_item_q), .menu_value_q(menu_value_q),
    .frame_fault_q(frame_fault_q), .irq_q(irq_q));

// ---- verification/tb_top.sv ----
// Self-checking bench for the serial channel configuration bank.
// Assumes the package, the design and the checker are compiled first.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sccb_pkg::*;

    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic key_up = 1'b0;
    logic key_down = 1'b0;
    logic key_push = 1'b0;
    logic fault_export_on = 1'b0;
    logic legacy_ctrl_jumper = 1'b0;
    logic link_end_letter = 1'b1;
    logic local_fault = 1'b0;
    logic [NUM_CH-1:0] shared_bus_q;
    logic [NUM_CH-1:0] term_en_q;
    logic [NUM_CH-1:0] bias_en_q;
    logic [NUM_CH*TMO_W-1:0] drv_timeout;
    logic [1:0] menu_level_q;
    logic [CH_W-1:0] menu_ch_q;
    logic [2:0] menu_item_q;
    logic [RATE_W-1:0] menu_value_q;
    logic frame_fault_q;
    logic irq_q;
    int num_errors = 0;
    int check_count = 0;
    integer seed = 66;
    logic [CFG_W-1:0] cfg_m [NUM_CH];
    logic [DATA_W-1:0] rd_v;

    sccb_bank #(.N_CH(NUM_CH)) i_dut (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .key_up(key_up),
        .key_down(key_down), .key_push(key_push), .fault_export_on(fault_export_on),
        .legacy_ctrl_jumper(legacy_ctrl_jumper), .link_end_letter(link_end_letter),
        .local_fault(local_fault), .shared_bus_q(shared_bus_q), .term_en_q(term_en_q),
        .bias_en_q(bias_en_q), .drv_timeout(drv_timeout), .menu_level_q(menu_level_q),
        .menu_ch_q(menu_ch_q), .menu_item_q(menu_item_q), .menu_value_q(menu_value_q),
        .frame_fault_q(frame_fault_q), .irq_q(irq_q));

    always #4 clk = ~clk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict;
        $display("errors=%0d checks=%0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [TMO_W-1:0] exp_tmo(input logic [CFG_W-1:0] c);
        if (!c[F_SHARED]) return '0;
        return TMO_W'((CLK_HZ / RATE_BPS[c[F_RATE_LSB +: RATE_W]]) * TMO_BITS);
    endfunction

    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask

    // Legacy jumper toggles at random on every write; nothing may follow it
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        legacy_ctrl_jumper <= 1'($random(seed));
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        rd_v = reg_rdata;
    endtask

    // Key codes: 0 up, 1 down, 2 push
    task automatic press(input int k);
        @(posedge clk);
        key_up <= (k == 0);
        key_down <= (k == 1);
        key_push <= (k == 2);
        @(posedge clk);
        key_up <= 1'b0;
        key_down <= 1'b0;
        key_push <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic check_all;
        for (int g = 0; g < NUM_CH; g++) begin
            check(shared_bus_q[g], cfg_m[g][F_SHARED]);
            check(term_en_q[g], cfg_m[g][F_TERM]);
            check(bias_en_q[g], cfg_m[g][F_BIAS] & cfg_m[g][F_TERM]);
            check(drv_timeout[g*TMO_W +: TMO_W], exp_tmo(cfg_m[g]));
            rd(ADDR_W'(g));
            check(rd_v, DATA_W'(cfg_m[g]));
        end
    endtask

    task automatic cfg_wr(input int ch, input logic [CFG_W-1:0] v);
        wr(ADDR_W'(ch), DATA_W'(v));
        if (v[RATE_W-1:0] > RATE_LAST) v[RATE_W-1:0] = cfg_m[ch][RATE_W-1:0];
        cfg_m[ch] = v;
        settle();
        check_all();
    endtask

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        give_verdict();
    end

    initial begin
        for (int g = 0; g < NUM_CH; g++) cfg_m[g] = CFG_W'(RATE_RESET);
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        settle();
        check(menu_level_q, MENU_LEVEL_1);
        check_all();
        rd(4'h7);
        check(rd_v, '0);
        // Every rate code, then a bad code with point-to-point
        for (int r = 0; r <= 12; r++) cfg_wr(r % NUM_CH, CFG_W'(8'h10 | r));
        cfg_wr(1, 7'h6e);
        repeat (30) cfg_wr($unsigned($random(seed)) % NUM_CH, CFG_W'($random(seed)));
        // Interrupt and fault export
        wr(REG_IRQ_MASK, 32'h1f);
        wr(REG_IRQ_STAT, 32'h1f);
        settle();
        check(irq_q, 1'b0);
        for (int f = 0; f < 4; f++) begin
            @(posedge clk);
            fault_export_on <= f[1];
            local_fault <= f[0];
            link_end_letter <= ~f[0];
            settle();
            check(frame_fault_q, f[0] & f[1]);
            rd(REG_STATUS);
            check(rd_v, DATA_W'({MENU_LEVEL_1, link_end_letter, f[1]}));
        end
        rd(REG_IRQ_STAT);
        check(rd_v, 32'h10);
        check(irq_q, 1'b1);
        wr(REG_IRQ_MASK, 32'h0);
        settle();
        check(irq_q, 1'b0);
        wr(REG_IRQ_STAT, 32'h10);
        cfg_wr(2, 7'h23);
        rd(REG_IRQ_STAT);
        check(rd_v, 32'h4);
        wr(REG_IRQ_MASK, 32'h4);
        settle();
        check(irq_q, 1'b1);
        wr(REG_IRQ_STAT, 32'h4);
        settle();
        check(irq_q, 1'b0);
        // Menu walk: edit rate of a shared-bus channel, then termination of a point-to-point channel
        cfg_wr(0, 7'h03);
        cfg_wr(1, 7'h13);
        press(2);
        check(menu_level_q, MENU_LEVEL_2);
        press(0);
        check(menu_ch_q, 2'h1);
        press(2);
        check(menu_item_q, 3'h0);
        press(0);
        check(menu_item_q, 3'h1);
        press(2);
        check(menu_value_q, 4'h3);
        press(0);
        press(2);
        check(menu_level_q, MENU_LEVEL_3);
        cfg_m[1][RATE_W-1:0] = 4'h4;
        check_all();
        repeat (3) press(0);
        check(menu_item_q, 3'h4);
        press(2);
        check(menu_level_q, MENU_LEVEL_2);
        press(1);
        press(2);
        press(0);
        check(menu_item_q, 3'h2);
        press(2);
        press(1);
        check(menu_value_q, 4'h1);
        press(2);
        cfg_m[0][F_TERM] = 1'b1;
        check_all();
        give_verdict();
    end
endmodule // tb_top
